// *** core/mppd_decoder.sv ***
// motion path decoder: stores 63 paths, decodes and sequences them
// assumes an avalon-mm master on the register side and a motion
// generator that reports completion on i_mg_done
`timescale 1ns/1ps

module mppd_decoder #(
  parameter int unsigned P_CYC_PER_MS = mppd_pkg::CYC_PER_MS
) (
  // clock, reset, enable
  input wire logic i_core_clk,
  input wire logic i_rstn,
  input wire logic i_ce,
  // avalon-mm slave
  input wire logic [9:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic o_avs_waitrequest,
  output logic [31:0] o_avs_readdata,
  // motion generator
  output logic o_cmd_valid,
  output logic o_cmd_is_pos,
  output logic o_cmd_unit_pps,
  output logic o_cmd_overlap,
  output logic [31:0] o_cmd_target,
  output logic [15:0] o_cmd_speed,
  output logic [15:0] o_cmd_accel_ms,
  output logic [15:0] o_cmd_decel_ms,
  output logic o_cmd_halt,
  output logic o_busy,
  input wire logic i_mg_done,
  input wire logic [31:0] i_fb_pos,
  // stop and software limits
  input wire logic i_stop,
  input wire logic i_swlimit
);

  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [15:0] clamp(input logic [15:0] v,
                                        input logic [15:0] hi);
    logic [15:0] r;
    r = v;
    if (v < mppd_pkg::TAB_MIN) begin
      r = mppd_pkg::TAB_MIN;
    end else if (v > hi) begin
      r = hi;
    end
    return r;
  endfunction

  // storage
  logic [31:0] func_mem [mppd_pkg::NUM_PATHS];
  logic [31:0] data_mem [mppd_pkg::NUM_PATHS];
  logic [15:0] speed_tab [mppd_pkg::TAB_SIZE];
  logic [15:0] ramp_tab [mppd_pkg::TAB_SIZE];
  logic [15:0] dwell_tab [mppd_pkg::TAB_SIZE];

  // bus state
  logic wait_q, wait_d;
  logic [31:0] rdata_q, rdata_d;
  logic take, wr_en;
  logic [1:0] bank;
  logic [6:0] pnum;
  logic is_path, is_func, is_tab;
  logic [5:0] pidx;
  logic [1:0] tab_sel;
  logic [3:0] tab_idx;
  logic [6:0] tab_off;
  logic [31:0] wmerged;

  // sequencer state
  mppd_pkg::mppd_state_t state_q, state_d;
  logic [5:0] cur_q, cur_d;
  logic [31:0] func_q, func_d;
  logic [31:0] data_q, data_d;
  logic [15:0] ms_q, ms_d;
  logic [31:0] cyc_q, cyc_d;
  logic [31:0] last_end_q, last_end_d;
  logic halted_q, halted_d, invalid_q, invalid_d, unsup_q, unsup_d;
  logic valid_q, valid_d, is_pos_q, is_pos_d, pps_q, pps_d;
  logic ovl_q, ovl_d, halt_q, halt_d, busy_q;
  logic [31:0] target_q, target_d;
  logic [15:0] cspeed_q, cspeed_d, accel_q, accel_d, decel_q, decel_d;

  // decoded fields of the fetched word
  logic [31:0] fw, dw, end_pos;
  logic [3:0] kind;
  logic [3:0] option;
  logic trig, abort;
  logic [5:0] trig_num;
  logic [31:0] trig_func;
  logic path_end;

  always_comb begin
    take = (i_avs_read | i_avs_write) & ~wait_q;
    wr_en = i_avs_write & take;
    bank = i_avs_address[9:8];
    pnum = i_avs_address[6:0];
    wmerged = i_avs_writedata;
    is_path = 1'b0;
    is_func = ~pnum[0];
    pidx = '0;
    is_tab = 1'b0;
    tab_sel = 2'h0;
    tab_off = '0;
    if (!i_avs_address[7] && bank == mppd_pkg::BANK_E &&
        pnum >= mppd_pkg::E_PATH_FIRST && pnum <= mppd_pkg::E_PATH_LAST) begin
      // odd parameter is the function word
      is_path = 1'b1;
      is_func = pnum[0];
      pidx = 6'((pnum - mppd_pkg::E_PATH_FIRST) >> 1);
    end else if (!i_avs_address[7] && bank == mppd_pkg::BANK_F) begin
      if (pnum >= mppd_pkg::F_PATH_FIRST && pnum <= mppd_pkg::F_PATH_LAST)
      begin
        is_path = 1'b1;
        is_func = pnum[0];
        pidx = 6'((pnum - mppd_pkg::F_PATH_FIRST) >> 1) +
               mppd_pkg::PATHS_IN_E;
      end else if (pnum >= mppd_pkg::F_SPEED_FIRST &&
                   pnum <= mppd_pkg::F_DWELL_LAST) begin
        is_tab = 1'b1;
        tab_off = pnum - mppd_pkg::F_SPEED_FIRST;
      end
    end
    tab_sel = tab_off[5:4];
    tab_idx = tab_off[3:0];
    rdata_d = '0;
    if (is_path) begin
      rdata_d = is_func ? func_mem[pidx] : data_mem[pidx];
    end else if (is_tab) begin
      unique case (tab_sel)
        2'h0: rdata_d = {16'h0000, speed_tab[tab_idx]};
        2'h1: rdata_d = {16'h0000, ramp_tab[tab_idx]};
        default: rdata_d = {16'h0000, dwell_tab[tab_idx]};
      endcase
    end else if (!i_avs_address[7] && bank == mppd_pkg::BANK_CTL) begin
      if (pnum == mppd_pkg::CTL_TRIGGER) begin
        rdata_d = {26'h0, cur_q};
      end else if (pnum == mppd_pkg::CTL_STATUS) begin
        rdata_d[5:0] = cur_q;
        rdata_d[mppd_pkg::STAT_HALTED_BIT] = halted_q;
        rdata_d[mppd_pkg::STAT_INVALID_BIT] = invalid_q;
        rdata_d[mppd_pkg::STAT_UNSUP_BIT] = unsup_q;
        rdata_d[mppd_pkg::STAT_BUSY_BIT] = busy_q;
      end else if (pnum == mppd_pkg::CTL_LAST_END) begin
        rdata_d = last_end_q;
      end
    end
    if (is_path) begin
      wmerged = merge(is_func ? func_mem[pidx] : data_mem[pidx],
                      i_avs_writedata, i_avs_byteenable);
    end else if (is_tab) begin
      wmerged = merge({16'h0000, rdata_d[15:0]}, i_avs_writedata,
                      i_avs_byteenable);
    end
    // one wait cycle per access; the answer stands while wait is low
    wait_d = ~((i_avs_read | i_avs_write) & wait_q);
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      wait_q <= 1'b1;
      rdata_q <= '0;
      for (int i = 0; i < mppd_pkg::NUM_PATHS; i++) begin
        func_mem[i] <= '0;
        data_mem[i] <= '0;
      end
      for (int i = 0; i < mppd_pkg::TAB_SIZE; i++) begin
        speed_tab[i] <= mppd_pkg::TAB_MIN;
        ramp_tab[i] <= mppd_pkg::TAB_MIN;
        dwell_tab[i] <= mppd_pkg::TAB_MIN;
      end
    end else if (i_ce) begin
      wait_q <= wait_d;
      rdata_q <= rdata_d;
      if (wr_en && is_path && is_func) begin
        func_mem[pidx] <= wmerged;
      end
      if (wr_en && is_path && !is_func) begin
        data_mem[pidx] <= wmerged;
      end
      // entries kept inside their legal ranges
      if (wr_en && is_tab && tab_sel == 2'h0) begin
        speed_tab[tab_idx] <= clamp(wmerged[15:0], mppd_pkg::SPEED_MAX);
      end
      if (wr_en && is_tab && tab_sel == 2'h1) begin
        ramp_tab[tab_idx] <= clamp(wmerged[15:0], mppd_pkg::RAMP_MAX);
      end
      if (wr_en && is_tab && tab_sel == 2'h2) begin
        dwell_tab[tab_idx] <= clamp(wmerged[15:0], mppd_pkg::DWELL_MAX);
      end
    end
  end

  // sequencer
  always_comb begin
    trig = wr_en && !i_avs_address[7] && bank == mppd_pkg::BANK_CTL &&
           pnum == mppd_pkg::CTL_TRIGGER;
    abort = trig & i_avs_writedata[mppd_pkg::TRIG_ABORT_BIT];
    trig_num = i_avs_writedata[5:0];
    trig_func = (trig_num == mppd_pkg::PATH_NONE) ? '0 :
                func_mem[trig_num - 6'h01];
    fw = func_mem[cur_q - 6'h01];
    dw = data_mem[cur_q - 6'h01];
    kind = func_q[mppd_pkg::TYPE_LSB +: 4];
    option = func_q[mppd_pkg::OPTION_LSB +: 4];
    end_pos = dw;
    unique case (fw[mppd_pkg::OPTION_LSB + mppd_pkg::OPT_MODE_LSB +: 2])
      mppd_pkg::MODE_REL: end_pos = i_fb_pos + dw;
      mppd_pkg::MODE_INC: end_pos = last_end_q + dw;
      default: end_pos = dw;
    endcase
    state_d = state_q;
    cur_d = cur_q;
    func_d = func_q;
    data_d = data_q;
    ms_d = ms_q;
    cyc_d = cyc_q;
    last_end_d = last_end_q;
    valid_d = 1'b0;
    halt_d = 1'b0;
    is_pos_d = is_pos_q;
    pps_d = pps_q;
    ovl_d = ovl_q;
    target_d = target_q;
    cspeed_d = cspeed_q;
    accel_d = accel_q;
    decel_d = decel_q;
    path_end = 1'b0;
    // status bits: write one clears, a new event in the same cycle wins
    halted_d = halted_q;
    invalid_d = invalid_q;
    unsup_d = unsup_q;
    if (wr_en && !i_avs_address[7] && bank == mppd_pkg::BANK_CTL &&
        pnum == mppd_pkg::CTL_STATUS) begin
      halted_d = halted_q & ~i_avs_writedata[mppd_pkg::STAT_HALTED_BIT];
      invalid_d = invalid_q & ~i_avs_writedata[mppd_pkg::STAT_INVALID_BIT];
      unsup_d = unsup_q & ~i_avs_writedata[mppd_pkg::STAT_UNSUP_BIT];
    end
    unique case (state_q)
      mppd_pkg::ST_IDLE: begin
      end
      mppd_pkg::ST_FETCH: begin
        // kind decoded before anything else is looked at
        func_d = fw;
        data_d = dw;
        state_d = mppd_pkg::ST_RUN;
        unique case (fw[mppd_pkg::TYPE_LSB +: 4])
          mppd_pkg::TYPE_SPEED: begin
            // motion generator ramps from present speed
            valid_d = 1'b1;
            is_pos_d = 1'b0;
            ovl_d = 1'b0;
            target_d = dw;
            pps_d = fw[mppd_pkg::OPTION_LSB + mppd_pkg::OPT_UNIT];
            cspeed_d = '0; // speed index unused here
            accel_d = ramp_tab[fw[mppd_pkg::ACCEL_LSB +: 4]];
            decel_d = ramp_tab[fw[mppd_pkg::DECEL_LSB +: 4]];
          end
          mppd_pkg::TYPE_POS_STOP, mppd_pkg::TYPE_POS_AUTO: begin
            if (fw[mppd_pkg::OPTION_LSB + mppd_pkg::OPT_MODE_LSB +: 2] ==
                2'h3) begin
              invalid_d = 1'b1;
              state_d = mppd_pkg::ST_IDLE;
            end else begin
              valid_d = 1'b1;
              is_pos_d = 1'b1;
              pps_d = 1'b0;
              target_d = end_pos;
              last_end_d = end_pos;
              cspeed_d = speed_tab[fw[mppd_pkg::SPEED_LSB +: 4]];
              accel_d = ramp_tab[fw[mppd_pkg::ACCEL_LSB +: 4]];
              decel_d = ramp_tab[fw[mppd_pkg::DECEL_LSB +: 4]];
              ovl_d = fw[mppd_pkg::OPTION_LSB + mppd_pkg::OPT_AUTO];
              if (fw[mppd_pkg::OPTION_LSB + mppd_pkg::OPT_AUTO]) begin
                // type 3: next path starts at once, no dwell; type 2 ends the sequence at once
                state_d = mppd_pkg::ST_ENDPATH;
              end
            end
          end
          mppd_pkg::TYPE_JUMP: begin
            // only dwell and preempt matter here
            ms_d = dwell_tab[fw[mppd_pkg::DWELL_LSB +: 4]];
            cyc_d = '0;
            state_d = mppd_pkg::ST_DWELL;
          end
          mppd_pkg::TYPE_PARAM_WR, mppd_pkg::TYPE_INDEX: begin
            unsup_d = 1'b1;
            state_d = mppd_pkg::ST_IDLE;
          end
          default: begin
            invalid_d = 1'b1; // no motion for unknown kinds
            state_d = mppd_pkg::ST_IDLE;
          end
        endcase
      end
      mppd_pkg::ST_RUN: begin
        if (i_mg_done) begin
          ms_d = dwell_tab[func_q[mppd_pkg::DWELL_LSB +: 4]];
          cyc_d = '0;
          state_d = mppd_pkg::ST_DWELL;
        end
      end
      mppd_pkg::ST_DWELL: begin
        if (cyc_q == P_CYC_PER_MS - 1) begin
          cyc_d = '0;
          ms_d = ms_q - 16'h0001;
          if (ms_q == mppd_pkg::TAB_MIN) begin
            state_d = mppd_pkg::ST_ENDPATH;
          end
        end else begin
          cyc_d = cyc_q + 32'h1;
        end
      end
      mppd_pkg::ST_ENDPATH: begin
        path_end = 1'b1;
      end
      default: begin
        state_d = mppd_pkg::ST_IDLE;
      end
    endcase
    if (path_end) begin
      state_d = mppd_pkg::ST_IDLE;
      if (kind == mppd_pkg::TYPE_JUMP) begin
        // data 0 stops; out of range counts as invalid
        if (data_q != '0 && data_q <= 32'(mppd_pkg::PATH_LAST)) begin
          cur_d = data_q[5:0];
          state_d = mppd_pkg::ST_FETCH;
        end else if (data_q != '0) begin
          invalid_d = 1'b1;
        end
      end else if (kind == mppd_pkg::TYPE_POS_AUTO ||
                   (kind == mppd_pkg::TYPE_SPEED &&
                    option[mppd_pkg::OPT_AUTO])) begin
        if (cur_q != mppd_pkg::PATH_LAST) begin
          cur_d = cur_q + 6'h01;
          state_d = mppd_pkg::ST_FETCH;
        end
      end
      // type 2 and plain speed paths end here
    end
    // stop input and limits end running motion
    if ((i_stop || i_swlimit) && state_q != mppd_pkg::ST_IDLE &&
        kind != mppd_pkg::TYPE_JUMP) begin
      halt_d = 1'b1;
      halted_d = 1'b1;
      state_d = mppd_pkg::ST_IDLE;
    end
    if (abort) begin
      halt_d = 1'b1;
      state_d = mppd_pkg::ST_IDLE;
    end else if (trig && trig_num != mppd_pkg::PATH_NONE &&
                 (state_q == mppd_pkg::ST_IDLE ||
                  trig_func[mppd_pkg::OPTION_LSB + mppd_pkg::OPT_PREEMPT]))
    begin
      // preempt replaces the running path at once
      cur_d = trig_num;
      state_d = mppd_pkg::ST_FETCH;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      state_q <= mppd_pkg::ST_IDLE;
      cur_q <= mppd_pkg::PATH_NONE;
      func_q <= '0;
      data_q <= '0;
      ms_q <= '0;
      cyc_q <= '0;
      last_end_q <= '0;
      halted_q <= 1'b0;
      invalid_q <= 1'b0;
      unsup_q <= 1'b0;
      valid_q <= 1'b0;
      is_pos_q <= 1'b0;
      pps_q <= 1'b0;
      ovl_q <= 1'b0;
      halt_q <= 1'b0;
      busy_q <= 1'b0;
      target_q <= '0;
      cspeed_q <= '0;
      accel_q <= '0;
      decel_q <= '0;
    end else if (i_ce) begin
      state_q <= state_d;
      cur_q <= cur_d;
      func_q <= func_d;
      data_q <= data_d;
      ms_q <= ms_d;
      cyc_q <= cyc_d;
      last_end_q <= last_end_d;
      halted_q <= halted_d;
      invalid_q <= invalid_d;
      unsup_q <= unsup_d;
      valid_q <= valid_d;
      is_pos_q <= is_pos_d;
      pps_q <= pps_d;
      ovl_q <= ovl_d;
      halt_q <= halt_d;
      busy_q <= (state_d != mppd_pkg::ST_IDLE);
      target_q <= target_d;
      cspeed_q <= cspeed_d;
      accel_q <= accel_d;
      decel_q <= decel_d;
    end
  end

  assign o_avs_waitrequest = wait_q;
  assign o_avs_readdata = rdata_q;
  assign o_cmd_valid = valid_q;
  assign o_cmd_is_pos = is_pos_q;
  assign o_cmd_unit_pps = pps_q;
  assign o_cmd_overlap = ovl_q;
  assign o_cmd_target = target_q;
  assign o_cmd_speed = cspeed_q;
  assign o_cmd_accel_ms = accel_q;
  assign o_cmd_decel_ms = decel_q;
  assign o_cmd_halt = halt_q;
  assign o_busy = busy_q;

endmodule

// *** core/mppd_pkg.sv ***
// constants, field layout and register map of the motion path decoder
// assumes a 100 MHz core clock and 32-bit word-addressed register access
package mppd_pkg;

  // timing
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned MS_PER_S = 1000;
  localparam int unsigned CYC_PER_MS = CLK_HZ / MS_PER_S;

  // register banks, selected by address bits 9:8
  localparam logic [1:0] BANK_E = 2'h0;
  localparam logic [1:0] BANK_F = 2'h1;
  localparam logic [1:0] BANK_CTL = 2'h2;

  // parameter numbers inside the banks
  localparam logic [6:0] E_PATH_FIRST = 7'h03;
  localparam logic [6:0] E_PATH_LAST = 7'h62;
  localparam logic [6:0] F_PATH_FIRST = 7'h01;
  localparam logic [6:0] F_PATH_LAST = 7'h1E;
  localparam logic [6:0] F_SPEED_FIRST = 7'h21;
  localparam logic [6:0] F_RAMP_FIRST = 7'h31;
  localparam logic [6:0] F_DWELL_FIRST = 7'h41;
  localparam logic [6:0] F_DWELL_LAST = 7'h50;

  // own control registers in the control bank
  localparam logic [6:0] CTL_TRIGGER = 7'h00;
  localparam logic [6:0] CTL_STATUS = 7'h01;
  localparam logic [6:0] CTL_LAST_END = 7'h02;
  localparam int unsigned TRIG_ABORT_BIT = 8;
  localparam int unsigned STAT_HALTED_BIT = 8;
  localparam int unsigned STAT_INVALID_BIT = 9;
  localparam int unsigned STAT_UNSUP_BIT = 10;
  localparam int unsigned STAT_BUSY_BIT = 16;

  // path numbering
  localparam logic [5:0] PATH_NONE = 6'h00;
  localparam logic [5:0] PATH_LAST = 6'h3F;
  localparam logic [5:0] PATHS_IN_E = 6'h30;
  localparam int unsigned NUM_PATHS = 63;
  localparam int unsigned TAB_SIZE = 16;

  // function word fields (lsb positions)
  localparam int unsigned TYPE_LSB = 0;
  localparam int unsigned OPTION_LSB = 4;
  localparam int unsigned ACCEL_LSB = 8;
  localparam int unsigned DECEL_LSB = 12;
  localparam int unsigned SPEED_LSB = 16;
  localparam int unsigned DWELL_LSB = 20;
  // option nibble bits
  localparam int unsigned OPT_PREEMPT = 0;
  localparam int unsigned OPT_AUTO = 1;
  localparam int unsigned OPT_UNIT = 2;
  localparam int unsigned OPT_MODE_LSB = 2;

  // path kinds
  localparam logic [3:0] TYPE_SPEED = 4'h1;
  localparam logic [3:0] TYPE_POS_STOP = 4'h2;
  localparam logic [3:0] TYPE_POS_AUTO = 4'h3;
  localparam logic [3:0] TYPE_JUMP = 4'h7;
  localparam logic [3:0] TYPE_PARAM_WR = 4'h8;
  localparam logic [3:0] TYPE_INDEX = 4'hA;

  // end position forming
  localparam logic [1:0] MODE_ABS = 2'h0;
  localparam logic [1:0] MODE_REL = 2'h1;
  localparam logic [1:0] MODE_INC = 2'h2;

  // table limits and reset values
  localparam logic [15:0] TAB_MIN = 16'h0001;
  localparam logic [15:0] SPEED_MAX = 16'h0BB8;
  localparam logic [15:0] RAMP_MAX = 16'hFFDC;
  localparam logic [15:0] DWELL_MAX = 16'h7FFF;

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_FETCH = 5'b00010,
    ST_RUN = 5'b00100,
    ST_DWELL = 5'b01000,
    ST_ENDPATH = 5'b10000
  } mppd_state_t;

endpackage

// *** verif/mppd_assertions.sv ***
// port-level checks on the motion path decoder
// assumes default bank layout and one core clock domain
`timescale 1ns/1ps
module mppd_checker #(
  parameter int unsigned P_CYC_PER_MS = 10
) (
  input wire logic i_core_clk, i_rstn, i_ce, i_avs_read, i_avs_write,
  input wire logic [9:0] i_avs_address,
  input wire logic [31:0] i_avs_writedata,
  input wire logic o_avs_waitrequest, o_cmd_valid, o_cmd_halt, o_busy,
  input wire logic o_cmd_overlap, o_cmd_is_pos, i_mg_done, i_stop,
  input wire logic i_swlimit
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rstn);
  logic trig;
  // a motion command is in flight until done, halt or idle
  logic run_q;
  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      run_q <= 1'b0;
    end else if (i_ce) begin
      run_q <= o_cmd_valid | (run_q & ~i_mg_done & o_busy & ~o_cmd_halt);
    end
  end
  assign trig = i_avs_write && !o_avs_waitrequest && i_ce && !o_busy &&
    i_avs_address == {mppd_pkg::BANK_CTL, 1'b0, mppd_pkg::CTL_TRIGGER} &&
    i_avs_writedata[5:0] != 6'h00;
  a_wait_once: assert property ((i_avs_read || i_avs_write) &&
    o_avs_waitrequest && i_ce |=> !o_avs_waitrequest)
    else $error("bus access not answered after one wait cycle");
  a_wait_short: assert property (!o_avs_waitrequest && i_ce |=>
    o_avs_waitrequest) else $error("waitrequest low too long");
  a_valid_pulse: assert property (o_cmd_valid && i_ce |=> !o_cmd_valid)
    else $error("command valid longer than one cycle");
  a_valid_busy: assert property (o_cmd_valid |-> o_busy)
    else $error("command issued while idle");
  a_trig_start: assert property (trig |-> ##[1:3] o_busy)
    else $error("trigger did not start the sequencer");
  a_stop_halts: assert property (run_q && o_busy && !o_cmd_overlap &&
    (i_stop || i_swlimit) && i_ce |=> o_cmd_halt)
    else $error("stop or limit did not halt motion");
  a_halt_pulse: assert property (o_cmd_halt && i_ce |=> !o_cmd_halt)
    else $error("halt longer than one cycle");
  a_halt_idle: assert property (o_cmd_halt |-> ##[0:2] !o_busy)
    else $error("sequencer busy after halt");
  c_pos: cover property (o_cmd_valid && o_cmd_is_pos);
  c_speed: cover property (o_cmd_valid && !o_cmd_is_pos);
  c_halt: cover property (o_cmd_halt);
endmodule

bind mppd_decoder mppd_checker #(.P_CYC_PER_MS(P_CYC_PER_MS)) u_mppd_checker (.*);

// *** verif/mppd_mg_model.sv ***
// motion generator stand-in: completion pulse after a set latency
// assumes one command in flight; a new command or halt drops the old
`timescale 1ns/1ps
module mppd_mg_model #(
  parameter logic [31:0] P_FB_INIT = 32'h00001000
) (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rstn,
  // commands
  input wire logic i_cmd_valid,
  input wire logic i_cmd_halt,
  input wire logic i_cmd_is_pos,
  input wire logic [31:0] i_cmd_target,
  input wire logic [7:0] i_lat,
  // completion and feedback
  output logic o_mg_done,
  output logic [31:0] o_fb_pos
);
  int cnt = 0;
  logic [31:0] end_q;
  logic pos_q;
  initial begin
    o_mg_done = 1'b0;
    o_fb_pos = P_FB_INIT;
  end
  always @(posedge i_core_clk) begin
    o_mg_done <= 1'b0;
    if (!i_rstn || i_cmd_halt) begin
      cnt <= 0;
    end else if (i_cmd_valid) begin
      cnt <= int'(i_lat);
      end_q <= i_cmd_target;
      pos_q <= i_cmd_is_pos;
    end else if (cnt == 1) begin
      cnt <= 0;
      o_mg_done <= 1'b1;
      if (pos_q) o_fb_pos <= end_q;
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end
  end
endmodule

// *** verif/tb.sv ***
// self-checking bench: register bus driver, path sequencer model
// assumes the decoder runs with 10 cycles per ms
`timescale 1ns/1ps
module tb;
  localparam logic [31:0] FB0 = 32'h00001000;
  typedef struct {
    logic pos, aux, quick;
    logic [31:0] tgt;
    logic [15:0] speed_index, acc, dec;
  } mppd_exp_t;
  logic i_core_clk = 1'b0, i_rstn = 1'b0, i_ce = 1'b1;
  logic i_avs_read = 1'b0, i_avs_write = 1'b0;
  logic i_stop = 1'b0, i_swlimit = 1'b0;
  logic [9:0] i_avs_address = 10'h000;
  logic [31:0] i_avs_writedata = 32'h0;
  logic [3:0] i_avs_byteenable = 4'hF;
  logic o_avs_waitrequest, o_cmd_valid, o_cmd_is_pos, o_cmd_unit_pps;
  logic o_cmd_overlap, o_cmd_halt, o_busy, i_mg_done;
  logic [31:0] o_avs_readdata, o_cmd_target, i_fb_pos;
  logic [15:0] o_cmd_speed, o_cmd_accel_ms, o_cmd_decel_ms;
  logic [7:0] mg_lat = 8'h06;
  integer seed = 32'h4852;
  int fails = 0, n_compared = 0, cyc = 0, halts = 0, t_last = 0;
  logic [31:0] fw [1:63], dw [1:63], fb_m, end_m, rd, r;
  logic [15:0] speed_index [16], rmp [16], dly [16];
  logic [3:0] kinds [4] = '{4'h7, 4'h5, 4'h8, 4'hA};
  mppd_exp_t q [$];

  always #5 i_core_clk = ~i_core_clk;

  mppd_decoder #(.P_CYC_PER_MS(10)) u_mppd_decoder (.*);
  mppd_mg_model #(.P_FB_INIT(FB0)) u_mppd_mg_model (.i_core_clk, .i_rstn,
    .i_cmd_valid(o_cmd_valid), .i_cmd_halt(o_cmd_halt),
    .i_cmd_is_pos(o_cmd_is_pos), .i_cmd_target(o_cmd_target),
    .i_lat(mg_lat), .o_mg_done(i_mg_done), .o_fb_pos(i_fb_pos));

  task automatic results;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic [127:0] got, exp, input string what);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t: %s got %0h want %0h", $time, what, got, exp);
    end
  endtask

  // holds the request until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [9:0] a,
                     input logic [31:0] wd);
    int k;
    k = 0;
    @(posedge i_core_clk);
    i_avs_address <= a;
    i_avs_write <= wr;
    i_avs_read <= !wr;
    i_avs_writedata <= wd;
    do begin
      @(posedge i_core_clk);
      k++;
    end while (o_avs_waitrequest !== 1'b0);
    rd = o_avs_readdata;
    i_avs_read <= 1'b0;
    i_avs_write <= 1'b0;
    chk(k, 2, "bus answer");
  endtask

  function automatic logic [9:0] pa(int n, int d);
    if (n <= 48) return {3'h0, 7'(2 * n + 1 + d)};
    return {3'h2, 7'(2 * (n - 48) - 1 + d)};
  endfunction

  function automatic logic [9:0] ta(logic [6:0] base, int i);
    return {3'h2, base + 7'(i)};
  endfunction

  task automatic setp(int n, logic [31:0] f, d);
    fw[n] = f;
    dw[n] = d;
    bus(1, pa(n, 0), f);
    bus(1, pa(n, 1), d);
  endtask

  // sequencer model: queues the commands a run from path n emits
  task automatic predict(int n);
    mppd_exp_t e;
    logic [31:0] f, d;
    bit ovl;
    ovl = 0;
    while (n >= 1 && n <= 63) begin
      f = fw[n];
      d = dw[n];
      e = '{0, f[6], ovl, d, 16'h0, rmp[f[11:8]], rmp[f[15:12]]};
      case (f[3:0])
        4'h1: begin
          q.push_back(e);
          ovl = 0;
          n = f[5] ? n + 1 : 0;
        end
        4'h2, 4'h3: begin
          case (f[7:6])
            2'h1: end_m = fb_m + d;
            2'h2: end_m = end_m + d;
            default: end_m = d;
          endcase
          e.pos = 1;
          e.aux = f[5];
          e.tgt = end_m;
          e.speed_index = speed_index[f[19:16]];
          q.push_back(e);
          fb_m = end_m;
          ovl = f[5];
          n = f[0] ? n + 1 : 0;
        end
        4'h7: n = int'(d);
        default: n = 0;
      endcase
    end
  endtask

  task automatic trig(int n);
    bus(1, {mppd_pkg::BANK_CTL, 1'b0, mppd_pkg::CTL_TRIGGER}, 32'(n));
  endtask

  task automatic idle_wait;
    int k;
    k = 0;
    repeat (3) @(posedge i_core_clk);
    while (o_busy !== 1'b0 && k < 3000) begin
      @(posedge i_core_clk);
      k++;
    end
    chk(o_busy, 0, "busy after run");
    chk(q.size(), 0, "commands missing");
  endtask

  always @(posedge i_core_clk) begin
    mppd_exp_t e;
    cyc++;
    if (cyc > 20000) begin
      chk(0, 1, "timeout");
      results();
    end
    if (o_cmd_halt === 1'b1) halts++;
    if (i_rstn && o_cmd_valid === 1'b1) begin
      if (q.size() == 0) chk(1, 0, "unexpected command");
      else begin
        e = q.pop_front();
        chk({o_cmd_is_pos, e.pos ? o_cmd_overlap : o_cmd_unit_pps,
             o_cmd_target, o_cmd_speed, o_cmd_accel_ms, o_cmd_decel_ms},
            {e.pos, e.aux, e.tgt, e.speed_index, e.acc, e.dec}, "command");
        if (e.quick) chk(cyc - t_last < 8, 1, "overlap start");
      end
      t_last = cyc;
    end
  end

  initial begin
    fb_m = FB0;
    end_m = 0;
    repeat (4) @(posedge i_core_clk);
    i_rstn <= 1'b1;
    bus(0, pa(63, 0), 0);
    chk(rd, 0, "path reset");
    bus(0, ta(mppd_pkg::F_RAMP_FIRST, 15), 0);
    chk(rd, 1, "table reset");
    bus(0, 10'h080, 0);
    chk(rd, 0, "unmapped read");
    bus(1, ta(mppd_pkg::F_SPEED_FIRST, 0), 32'h0000FFFF);
    bus(0, ta(mppd_pkg::F_SPEED_FIRST, 0), 0);
    chk(rd, 32'(mppd_pkg::SPEED_MAX), "speed ceiling");
    bus(1, ta(mppd_pkg::F_DWELL_FIRST, 0), 0);
    bus(0, ta(mppd_pkg::F_DWELL_FIRST, 0), 0);
    chk(rd, 1, "dwell floor");
    for (int i = 0; i < 16; i++) begin
      speed_index[i] = 16'(1 + {$random(seed)} % 3000);
      rmp[i] = 16'(1 + {$random(seed)} % 65500);
      dly[i] = 16'(1 + {$random(seed)} % 2);
      bus(1, ta(mppd_pkg::F_SPEED_FIRST, i), 32'(speed_index[i]));
      bus(1, ta(mppd_pkg::F_RAMP_FIRST, i), 32'(rmp[i]));
      bus(1, ta(mppd_pkg::F_DWELL_FIRST, i), 32'(dly[i]));
    end
    setp(48, $random(seed), $random(seed));
    bus(0, pa(48, 0), 0);
    chk(rd, fw[48], "last bank E path");
    r = $random(seed);
    // junk in unused nibbles must not matter
    setp(1, {r[31:24], 4'h0, r[19:16], 16'h3F61}, $random(seed));
    setp(2, {r[7:0], 24'h025563}, $random(seed));
    setp(3, {12'h00E, 20'h01183}, $random(seed));
    setp(4, {r[15:8], 4'h1, r[11:0], 8'hE7}, 32'd49);
    setp(49, {12'h00F, 20'hDE002}, $random(seed));
    predict(1);
    trig(1);
    idle_wait();
    for (int i = 0; i < 4; i++) begin
      r = $random(seed);
      setp(50 + i, {r[31:4], kinds[i]}, i == 0 ? 32'h0 : r);
      predict(50 + i);
      trig(50 + i);
      idle_wait();
    end
    setp(60, {12'h003, 20'h21002}, $random(seed));
    mg_lat <= 8'd40;
    for (int i = 0; i < 2; i++) begin
      halts = 0;
      predict(60);
      trig(60);
      repeat (3) @(posedge i_core_clk);
      i_stop <= (i == 0);
      i_swlimit <= (i == 1);
      repeat (3) @(posedge i_core_clk);
      i_stop <= 1'b0;
      i_swlimit <= 1'b0;
      chk(halts, 1, "halt pulse");
      idle_wait();
    end
    bus(0, {mppd_pkg::BANK_CTL, 1'b0, mppd_pkg::CTL_STATUS}, 0);
    chk(rd[10:8], 3'h7, "status flags");
    bus(1, {mppd_pkg::BANK_CTL, 1'b0, mppd_pkg::CTL_STATUS}, 32'h700);
    bus(0, {mppd_pkg::BANK_CTL, 1'b0, mppd_pkg::CTL_STATUS}, 0);
    chk(rd[10:8], 3'h0, "status clear");
    setp(61, {12'h001, 20'h00002}, $random(seed));
    setp(62, {12'h000, 20'h45111}, $random(seed));
    predict(60);
    trig(60);
    repeat (3) @(posedge i_core_clk);
    trig(61);
    predict(62);
    trig(62);
    idle_wait();
    results();
  end
endmodule
